// ===== rpc_pkg.sv
// Constants shared by the receiver polling controller files.
// Assumes a 250 MHz system clock; crystal clock arrives as a pin.
package rpc_pkg;
    localparam int unsigned SLEEP_W        = 5;
    localparam logic [4:0]  SLEEP_PERM     = 5'h1f;    // Highest word: permanent sleep
    localparam int unsigned SLEEP_UNIT     = 1024;     // Base ticks per sleep step
    localparam logic [3:0]  XSLEEP_EXT     = 4'h8;     // Extension factor when extended
    localparam logic [3:0]  XSLEEP_STD     = 4'h1;
    localparam int unsigned DIV_MODE_LO    = 10;       // Crystal edges per base tick, mode low
    localparam int unsigned DIV_MODE_HI    = 14;       // Crystal edges per base tick, mode high
    localparam int unsigned STARTUP_XTICKS = 16;       // Start-up length in extended ticks
    localparam int unsigned FAIL_XTICKS    = 64;       // Bit check abort time in extended ticks
    localparam int unsigned CNT_W          = 20;
    localparam logic [4:0]  BITS_PER_STEP  = 5'h3;     // Checked-bit step of the count field
endpackage

// ===== rpc_tick_if.sv
// Tick bundle between the controller and its tick generator.
// Assumes one clock domain on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface rpc_tick_if;
    logic       base_tick;      // One-cycle pulse per base tick
    logic       extended_tick;  // One-cycle pulse per extended tick
    logic [1:0] baud_range_select;
    logic       clock_mode_sel;
    logic       xtal_s;         // Synchronised crystal level
    modport gen (input baud_range_select, clock_mode_sel, xtal_s, output base_tick, extended_tick);
    modport ctl (output baud_range_select, clock_mode_sel, xtal_s, input base_tick, extended_tick);
endinterface
`default_nettype wire

// ===== rpc_tick_gen.sv
// Base and extended tick generator.
// Assumes the crystal level is already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rpc_tick_gen (
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    rpc_tick_if.gen    tk
);
    logic       xtal_d1_q;
    logic [3:0] div_q;
    logic [2:0] xdiv_q;
    logic       base_q;
    logic       ext_q;
    wire        xtal_rise = tk.xtal_s & ~xtal_d1_q;
    // Division factor chosen by mode pin
    wire  [3:0] div_last  = tk.clock_mode_sel ? 4'(rpc_pkg::DIV_MODE_HI - 1) : 4'(rpc_pkg::DIV_MODE_LO - 1);
    // Extended tick length 8,4,2,1 base ticks for ranges 0..3
    wire  [2:0] xdiv_last = 3'(4'h8 >> tk.baud_range_select) - 3'h1;
    // Crystal divider to base tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_d1_q <= 1'b0;
            div_q     <= 4'h0;
            base_q    <= 1'b0;
        end else begin
            xtal_d1_q <= tk.xtal_s;
            base_q    <= 1'b0;
            if (xtal_rise) begin
                if (div_q >= div_last) begin
                    div_q  <= 4'h0;
                    base_q <= 1'b1;
                end else begin
                    div_q <= div_q + 4'h1;
                end
            end
        end
    end
    // Base tick to extended tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xdiv_q <= 3'h0;
            ext_q  <= 1'b0;
        end else begin
            ext_q <= 1'b0;
            if (base_q) begin
                if (xdiv_q >= xdiv_last) begin
                    xdiv_q <= 3'h0;
                    ext_q  <= 1'b1;
                end else begin
                    xdiv_q <= xdiv_q + 3'h1;
                end
            end
        end
    end
    assign tk.base_tick     = base_q;
    assign tk.extended_tick = ext_q;
    chk_ext_on_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ext_q |-> $past(base_q)) else $error("extended tick without base tick");
    chk_base_on_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        base_q |-> $past(xtal_rise)) else $error("base tick without crystal edge");
endmodule
`default_nettype wire

// ===== rpc_ctrl.sv
// Receiver polling controller: sleep, start-up and bit-check sequencing.
// Assumes an external edge-window checker reporting bit pass/fail pulses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Signal path on only in short bursts; stays on after a confirmed transmitter.
// - Polling loops sleep, start-up, bit check in that order.
// - Signal processing held off through sleep, which ends early when a non-permanent word is written.
// - Start-up enables circuits; length from baud range and base tick.
// - Failed bit check returns to sleep at its end.
// - Base tick is the crystal divided by a factor set by mode pin.
// - Extended tick is 8, 4, 2 or 1 base ticks for ranges 0..3.
// - Sleep equals sleep word times extension times 1024 base ticks.
// - Persistent extension bit forces factor 8 on every sleep.
// - Temporary extension kept while checks pass; cleared on first failure.
// - Highest sleep word means permanent sleep until a new word.
// - Baud range comes from two rate-select bits.
// - Passing check lasts per bit count; failing check bounded per baud range.
// - Transmitter input ignored in sleep and start-up.
// - Sleep word, baud range, bit count and both extension bits are writable by the host.
// - Host link is one shared line or up to three separate lines.
// - Base tick times the whole polling sequence.
// - All bits passed: enter receiving, route data out until told to poll.
// - Checked-bit count selectable as 0, 3, 6 or 9 bits.
module rpc_ctrl (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       crystal_oscillator,
    input  wire logic       clock_mode_sel,
    input  wire logic       cfg_write,
    input  wire logic [4:0] cfg_sleep_word,
    input  wire logic       rate_select_bit_low,
    input  wire logic       rate_select_bit_high,
    input  wire logic       persistent_extension_bit,
    input  wire logic       temporary_extension_set,
    input  wire logic [1:0] cfg_bitcheck_count,
    input  wire logic       return_to_polling,
    input  wire logic       demod_data,
    input  wire logic       edge_pass,
    input  wire logic       edge_fail,
    output logic            signal_path_en,
    output logic            bitcheck_active,
    output logic            receiving_mode,
    output logic            data_out,
    output logic            data_out_en,
    output logic            temporary_extension_bit,
    output logic            extended_tick,
    output logic [3:0]      poll_state
);
    typedef enum logic [3:0] {
        RPC_SLEEP   = 4'h1,
        RPC_STARTUP = 4'h2,
        RPC_CHECK   = 4'h4,
        RPC_RECEIVE = 4'h8
    } rpc_state_t;

    rpc_tick_if tk ();

    logic [1:0]  rst_sync_q;
    logic [1:0]  xtal_sync_q;
    logic [1:0]  dem_sync_q;
    logic [1:0]  mode_sync_q;
    wire         rst_n = rst_sync_q[1];
    rpc_state_t  state_q;
    rpc_state_t  state_d;
    logic [4:0]  sleep_word_q;
    logic [1:0]  range_q;
    logic [1:0]  nbits_q;
    logic        xstd_q;
    logic        xtemp_q;
    logic [19:0] cnt_q;
    logic [4:0]  bits_q;
    logic        data_q;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Pin inputs synchronised; first flop read only by the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_sync_q <= 2'h0;
            dem_sync_q  <= 2'h0;
            mode_sync_q <= 2'h0;
        end else begin
            xtal_sync_q <= {xtal_sync_q[0], crystal_oscillator};
            dem_sync_q  <= {dem_sync_q[0], demod_data};
            mode_sync_q <= {mode_sync_q[0], clock_mode_sel};
        end
    end

    assign tk.xtal_s            = xtal_sync_q[1];
    assign tk.clock_mode_sel    = mode_sync_q[1];
    assign tk.baud_range_select = range_q;

    rpc_tick_gen u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tk      (tk.gen)
    );

    // Derived figures
    wire        base_tick = tk.base_tick;
    wire        ext_tick  = tk.extended_tick;
    wire [3:0]  xsleep    = (xstd_q | xtemp_q) ? rpc_pkg::XSLEEP_EXT : rpc_pkg::XSLEEP_STD;
    wire [19:0] sleep_len = 20'(sleep_word_q * xsleep * 20'(rpc_pkg::SLEEP_UNIT));
    // Loaded one short: the tick that finds zero is itself the last sleep tick
    wire [19:0] sleep_load = (sleep_len == 20'h0) ? 20'h0 : sleep_len - 20'h1;
    wire        perm_sleep = (sleep_word_q == rpc_pkg::SLEEP_PERM);
    wire [4:0]  bits_need = 5'(nbits_q * rpc_pkg::BITS_PER_STEP);
    wire        cnt_zero  = (cnt_q == 20'h0);
    wire        chk_pass_all = (state_q == RPC_CHECK) && ((bits_need == 5'h0) ||
                               (edge_pass && (bits_q + 5'h1 >= bits_need)));
    wire        chk_fail  = (state_q == RPC_CHECK) && !chk_pass_all &&
                            (edge_fail || (ext_tick && cnt_zero));

    // Host configuration writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_word_q <= 5'h0;
            range_q      <= 2'h0;
            nbits_q      <= 2'h0;
            xstd_q       <= 1'b0;
        end else if (cfg_write) begin
            sleep_word_q <= cfg_sleep_word;
            range_q      <= {rate_select_bit_high, rate_select_bit_low};
            nbits_q      <= cfg_bitcheck_count;
            xstd_q       <= persistent_extension_bit;
        end
    end

    // Temporary extension: a failure clears unless a write sets it the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtemp_q <= 1'b0;
        end else if (cfg_write && temporary_extension_set) begin
            xtemp_q <= 1'b1;
        end else if (cfg_write) begin
            xtemp_q <= 1'b0;
        end else if (chk_fail) begin
            xtemp_q <= 1'b0;
        end
    end

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            RPC_SLEEP: begin
                if (!perm_sleep && base_tick && cnt_zero) begin
                    state_d = RPC_STARTUP;
                end
            end
            RPC_STARTUP: begin
                if (ext_tick && cnt_zero) begin
                    state_d = RPC_CHECK;
                end
            end
            RPC_CHECK: begin
                if (chk_pass_all) begin
                    state_d = RPC_RECEIVE;
                end else if (chk_fail) begin
                    state_d = RPC_SLEEP;
                end
            end
            RPC_RECEIVE: begin
                if (return_to_polling) begin
                    state_d = RPC_SLEEP;
                end
            end
            default: state_d = RPC_SLEEP;
        endcase
    end

    // Phase counter: base ticks in sleep, extended ticks elsewhere
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RPC_SLEEP;
            cnt_q   <= 20'h0;
        end else begin
            state_q <= state_d;
            if (state_d == RPC_SLEEP && state_q != RPC_SLEEP) begin
                cnt_q <= sleep_load;
            end else if (state_d == RPC_STARTUP && state_q != RPC_STARTUP) begin
                cnt_q <= 20'(rpc_pkg::STARTUP_XTICKS - 1);
            end else if (state_d == RPC_CHECK && state_q != RPC_CHECK) begin
                cnt_q <= 20'(rpc_pkg::FAIL_XTICKS - 1);
            end else if (state_q == RPC_SLEEP && cfg_write && cfg_sleep_word != rpc_pkg::SLEEP_PERM) begin
                cnt_q <= 20'h0; // Any non-permanent word written during sleep zeroes the count, so the next base tick ends sleep
            end else if (state_q == RPC_SLEEP ? base_tick : ext_tick) begin
                if (!cnt_zero) begin
                    cnt_q <= cnt_q - 20'h1;
                end
            end
        end
    end

    // Checked-bit tally within one bit check
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_q <= 5'h0;
        end else if (state_q != RPC_CHECK) begin
            bits_q <= 5'h0;
        end else if (edge_pass) begin
            bits_q <= bits_q + 5'h1;
        end
    end

    // Data routed to the host pin only while receiving
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 1'b1;
        end else if (state_q == RPC_RECEIVE && ext_tick) begin
            data_q <= dem_sync_q[1];
        end else if (state_q != RPC_RECEIVE) begin
            data_q <= 1'b1;
        end
    end

    // Outputs
    assign signal_path_en          = (state_q != RPC_SLEEP);
    assign bitcheck_active         = (state_q == RPC_CHECK);
    assign receiving_mode          = (state_q == RPC_RECEIVE);
    assign data_out                = data_q;
    assign data_out_en             = (state_q == RPC_RECEIVE);
    assign temporary_extension_bit = xtemp_q;
    assign extended_tick           = ext_tick;
    assign poll_state              = state_q;

    // Checks
    chk_order_sleep_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_SLEEP && state_d != RPC_SLEEP) |-> state_d == RPC_STARTUP)
        else $error("sleep not followed by start-up");
    chk_sleep_path_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_SLEEP && !cnt_zero) |=> !signal_path_en || $past(cfg_write))
        else $error("path enabled during sleep");
    chk_perm_sleep_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_SLEEP && perm_sleep && !cfg_write) |=> state_q == RPC_SLEEP)
        else $error("left permanent sleep");
    chk_fail_to_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chk_fail |=> state_q == RPC_SLEEP)
        else $error("failed check did not sleep");
    chk_temp_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (chk_fail && !cfg_write) |=> !temporary_extension_bit)
        else $error("temporary extension kept after failure");
    chk_sleep_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_CHECK && state_d == RPC_SLEEP) |=> cnt_q == $past(sleep_load))
        else $error("sleep counter not reloaded");
    chk_ext_factor: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xstd_q |-> xsleep == 4'h8)
        else $error("persistent extension ignored");
    chk_receive_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (receiving_mode && !return_to_polling) |=> receiving_mode && data_out_en)
        else $error("receiving mode dropped");
    chk_startup_enabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == RPC_STARTUP |-> signal_path_en && !bitcheck_active)
        else $error("start-up path state wrong");

    // Order of the later phases, a host line kept quiet while polling, and edges ignored in start-up
    chk_order_startup_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_STARTUP && state_d != RPC_STARTUP) |-> state_d == RPC_CHECK)
        else $error("start-up not followed by bit check");
    chk_check_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q != RPC_CHECK && state_d == RPC_CHECK) |-> state_q == RPC_STARTUP)
        else $error("bit check entered out of order");
    chk_data_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !receiving_mode |=> data_out)
        else $error("data line moved while polling");
    chk_pass_to_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chk_pass_all |=> receiving_mode)
        else $error("passed check did not enter receiving");
    chk_startup_deaf: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == RPC_STARTUP && edge_pass) |=> bits_q == 5'h0)
        else $error("edge counted during start-up");

    // Extended ticks spent in one bit check; a hang here would keep the path on
    logic [6:0] xt_in_check_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xt_in_check_q <= 7'h0;
        end else if (state_q != RPC_CHECK) begin
            xt_in_check_q <= 7'h0;
        end else if (ext_tick) begin
            xt_in_check_q <= xt_in_check_q + 7'h1;
        end
    end
    chk_check_bounded: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xt_in_check_q <= 7'(rpc_pkg::FAIL_XTICKS))
        else $error("bit check outlasted its bound");

    cov_full_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == RPC_STARTUP ##1 state_q == RPC_CHECK);
    cov_receive: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == RPC_CHECK ##1 state_q == RPC_RECEIVE);
    cov_fail: cover property (@(posedge sys_clk) disable iff (!rst_n) chk_fail);
    cov_temp_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
        xtemp_q ##1 !xtemp_q);
    cov_perm_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == RPC_SLEEP && perm_sleep && cfg_write);
endmodule
`default_nettype wire

// ===== rpc_partner.sv
// Stand-in for the far side: edge checker pulses as a transmitter would cause.
// Assumes the controller's phase outputs on the one clock, sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rpc_partner (
    input  wire logic       sys_clk,
    input  wire logic       signal_path_en,
    input  wire logic       bitcheck_active,
    input  wire logic [3:0] npass,
    input  wire logic       early,
    input  wire logic       give_fail,
    output logic            edge_pass,
    output logic            edge_fail
);
    int  gap_q  = 0;
    int  sent_q = 0;
    wire live   = early ? signal_path_en : bitcheck_active;
    wire due    = live && (gap_q % 4 == 3);

    // Quiet at time zero, before the first edge
    initial begin
        edge_pass = 1'b0;
        edge_fail = 1'b0;
    end

    // One good bit every four cycles, then an optional fault; early mode fires in start-up
    always @(posedge sys_clk) begin
        edge_pass <= due && (sent_q < npass);
        edge_fail <= due && give_fail && (sent_q == npass);
        gap_q     <= signal_path_en ? (live ? gap_q + 1 : gap_q) : 0;
        sent_q    <= signal_path_en ? (due ? sent_q + 1 : sent_q) : 0;
    end
endmodule
`default_nettype wire

// ===== receiver_polling_controller_tb.sv
// Self-checking bench for the polling controller and its far-side model.
// Assumes rpc_pkg, the tick files, rpc_ctrl and rpc_partner compiled first.
`timescale 1ns/1ps
`default_nettype none
module receiver_polling_controller_tb;
    logic       sys_clk = 1'b0;
    logic       nrst    = 1'b0;
    logic       xtal    = 1'b0;
    logic       mode    = 1'b0;
    logic       wr      = 1'b0;
    logic [4:0] word    = 5'h1f;
    logic [1:0] rng     = 2'h3;
    logic       pers    = 1'b0;
    logic       tmp     = 1'b0;
    logic [1:0] cnt     = 2'h0;
    logic       rtp     = 1'b0;
    logic       demod   = 1'b1;
    logic [3:0] npass   = 4'h0;
    logic       early   = 1'b0;
    logic       gfail   = 1'b0;
    logic       epass;
    logic       efail;
    logic       path_en;
    logic       chk_act;
    logic       rx;
    logic       dout;
    logic       dout_en;
    logic       tmp_q;
    logic       xtick;
    logic [3:0] st;
    int         bad_count    = 0;
    int         total_checks = 0;

    // 250 MHz system clock; crystal at 100 MHz with an unrelated phase
    always #2 sys_clk = ~sys_clk;
    initial begin
        #1.7;
        forever #5 xtal = ~xtal;
    end

    rpc_ctrl DUT (
        .sys_clk                  (sys_clk),
        .nrst                     (nrst),
        .crystal_oscillator       (xtal),
        .clock_mode_sel           (mode),
        .cfg_write                (wr),
        .cfg_sleep_word           (word),
        .rate_select_bit_low      (rng[0]),
        .rate_select_bit_high     (rng[1]),
        .persistent_extension_bit (pers),
        .temporary_extension_set  (tmp),
        .cfg_bitcheck_count       (cnt),
        .return_to_polling        (rtp),
        .demod_data               (demod),
        .edge_pass                (epass),
        .edge_fail                (efail),
        .signal_path_en           (path_en),
        .bitcheck_active          (chk_act),
        .receiving_mode           (rx),
        .data_out                 (dout),
        .data_out_en              (dout_en),
        .temporary_extension_bit  (tmp_q),
        .extended_tick            (xtick),
        .poll_state               (st)
    );

    rpc_partner partner (
        .sys_clk         (sys_clk),
        .signal_path_en  (path_en),
        .bitcheck_active (chk_act),
        .npass           (npass),
        .early           (early),
        .give_fail       (gfail),
        .edge_pass       (epass),
        .edge_fail       (efail)
    );

    // Inputs always change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Durations carry crystal sampling jitter, hence a tolerance
    task automatic near(input int n, input int e, input int tol);
        check(32'((n >= e - tol) && (n <= e + tol)), 32'h1);
    endtask

    task automatic end_of_test;
        $display("checks=%0d bad=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cfg(input logic [4:0] w, input logic [1:0] r, input logic p, input logic t, input logic [1:0] c);
        word = w;
        rng  = r;
        pers = p;
        tmp  = t;
        cnt  = c;
        wr   = 1'b1;
        step(1);
        wr   = 1'b0;
        step(1);
    endtask

    task automatic wait_for(input logic [3:0] s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            step(1);
            n++;
        end
        if (st !== s) begin
            check(st, s);
            end_of_test();
        end
    endtask

    task automatic stay(input logic [3:0] s, input int lim, output int n);
        n = 0;
        while (st === s && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic tick_gap(output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (xtick !== 1'b1 && n < 400);
    endtask

    // Polls once that should not reach receive; n is the check-phase length
    task automatic miss(input logic [3:0] p, input logic e, input logic f, input logic [1:0] c, output int n);
        npass = p;
        early = e;
        gfail = f;
        cfg(5'h00, 2'h3, 1'b0, 1'b0, c);
        wait_for(4'h1, 3000);
        wait_for(4'h2, 100);
        stay(4'h2, 3000, n);
        stay(4'h4, 3000, n);
        early = 1'b0;
        gfail = 1'b0;
    endtask

    task automatic t_ticks;
        int n;
        for (int m = 0; m < 2; m++) begin
            for (int r = 0; r < 4; r++) begin
                mode = m[0];
                cfg(5'h1f, 2'(r), 1'b0, 1'b0, 2'h0);
                tick_gap(n);
                tick_gap(n);
                tick_gap(n);
                near(n, (8 >> r) * (m == 1 ? 14 : 10) * 5 / 2, 1);
            end
        end
        mode = 1'b0;
        $display("done ticks");
    endtask

    task automatic t_fail;
        int n;
        npass = 4'h0;
        demod = 1'b0;
        cfg(5'h00, 2'h3, 1'b0, 1'b1, 2'h1);
        check(tmp_q, 1'b1);
        wait_for(4'h2, 3000);
        check(path_en, 1'b1);
        stay(4'h2, 3000, n);
        near(n, 400, 25);
        check(st, 4'h4);
        check(chk_act, 1'b1);
        check(dout, 1'b1);
        stay(4'h4, 3000, n);
        near(n, 1600, 25);
        check(st, 4'h1);
        check(path_en, 1'b0);
        check(dout_en, 1'b0);
        check(tmp_q, 1'b0);
        demod = 1'b1;
        $display("done fail");
    endtask

    task automatic t_pass;
        for (int c = 0; c < 4; c++) begin
            npass = 4'(3 * c);
            cfg(5'h00, 2'h3, 1'b0, 1'b0, 2'(c));
            wait_for(4'h2, 3000);
            wait_for(4'h8, 3000);
            check(rx, 1'b1);
            check(dout_en, 1'b1);
            check(path_en, 1'b1);
            demod = 1'b0;
            step(100);
            check(dout, 1'b0);
            demod = 1'b1;
            step(100);
            check(dout, 1'b1);
            rtp = 1'b1;
            step(1);
            rtp = 1'b0;
            step(1);
            check(rx, 1'b0);
        end
        npass = 4'h0;
        $display("done pass");
    endtask

    task automatic t_misses;
        int n;
        miss(4'h3, 1'b1, 1'b0, 2'h1, n);
        check(st, 4'h1);
        miss(4'h8, 1'b0, 1'b0, 2'h3, n);
        check(st, 4'h1);
        miss(4'h3, 1'b0, 1'b1, 2'h2, n);
        check(st, 4'h1);
        near(n, 17, 4);
        $display("done misses");
    endtask

    task automatic t_sleep;
        int n;
        npass = 4'h0;
        cfg(5'h1f, 2'h3, 1'b0, 1'b0, 2'h1);
        wait_for(4'h1, 3000);
        stay(4'h1, 5000, n);
        check(n, 5000);
        cfg(5'h01, 2'h3, 1'b0, 1'b0, 2'h1);
        wait_for(4'h2, 40);
        check(st, 4'h2);
        wait_for(4'h4, 3000);
        stay(4'h4, 3000, n);
        stay(4'h1, 30000, n);
        near(n, 25600, 60);
        cfg(5'h01, 2'h3, 1'b1, 1'b0, 2'h1);
        wait_for(4'h4, 3000);
        stay(4'h4, 3000, n);
        stay(4'h1, 38400, n);
        check(n, 38400);
        $display("done sleep");
    endtask

    // Reset state is checked while reset is still held
    initial begin
        step(2);
        check(st, 4'h1);
        check(path_en, 1'b0);
        check(dout, 1'b1);
        check(rx, 1'b0);
        nrst = 1'b1;
        step(4);
        t_ticks();
        t_fail();
        t_pass();
        t_misses();
        t_sleep();
        end_of_test();
    end
endmodule
`default_nettype wire
